/* design/loss_detect_pkg.sv */
// Summary of operation
// - One sample per channel is judged every clock; 8 ns spacing at 125 MHz.
// - Tube voltage set point is a count; 1250 means full-scale 5 V, scaled linearly.
// - One programmed threshold is compared against each channel independently.
// - A programmed window counts samples at or above threshold before a loss.
// - Full window met: raise limit-exceeded and stop writing the capture buffer.
// - Each 14-bit sample is sign-extended to 32 bits before capture.
// - On a loss the protection output goes low and stays latched low.
// - A user reset releases protection, clears limit flag and unfreezes the buffer.
// - A second output reproduces the trigger signal for debugging.
package loss_detect_pkg;

    // ----------------------------------------
    // Sample format and timing
    // ----------------------------------------
    localparam int ADC_W = 14;
    localparam int WORD_W = 32;
    localparam int SAMPLE_RATE_MHZ = 125;
    localparam int SAMPLE_PERIOD_NS = 1000 / SAMPLE_RATE_MHZ;
    localparam int SAMPLES_PER_CLK = 1;
    localparam int NUM_CH = 2;

    // ----------------------------------------
    // Set point scaling
    // ----------------------------------------
    localparam int SETPOINT_W = 11;
    localparam logic [SETPOINT_W-1:0] SETPOINT_MAX = 11'h4E2;
    localparam int SETPOINT_FULL_SCALE_MV = 5000;

    // ----------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_THRESHOLD = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_WINDOW = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_SETPOINT = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_CAP_INDEX = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_CAP_DATA_A = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_CAP_DATA_B = 12'h01C;
    localparam logic [ADDR_W-1:0] OFS_CAP_WPTR = 12'h020;

    localparam int CONTROL_RESET_BIT = 0;
    localparam int STATUS_LIMIT_BIT = 0;
    localparam int STATUS_PROTECT_BIT = 1;
    localparam int STATUS_STALL_BIT = 2;
    localparam int STATUS_TRIG_BIT = 3;

    localparam logic [WORD_W-1:0] THRESHOLD_RST = 32'h0000_1FFF;
    localparam logic [SETPOINT_W-1:0] SETPOINT_RST = 11'h000;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic [ADC_W-1:0] ch_b;
        logic [ADC_W-1:0] ch_a;
    } sample_pair_t;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [WORD_W-1:0] sign_extend(input logic [ADC_W-1:0] s);
        return {{(WORD_W-ADC_W){s[ADC_W-1]}}, s};
    endfunction

    function automatic logic at_or_above(input logic [ADC_W-1:0] s,
                                         input logic [WORD_W-1:0] thr);
        return $signed(sign_extend(s)) >= $signed(thr);
    endfunction

endpackage

/* design/skid_fifo.sv */
`timescale 1ns/1ps
module skid_fifo
    import loss_detect_pkg::*;
#(
    parameter int WIDTH = 2 * ADC_W,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("skid_fifo depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [CNT_W-1:0] count, next_count;
    logic next_in_ready;
    logic push, pop;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (push) begin
            next_mem[wr_ptr] = in_data;
            next_wr_ptr = wr_ptr + PTR_W'(1);
        end
        if (pop) begin
            next_rd_ptr = rd_ptr + PTR_W'(1);
        end
        next_count = count + CNT_W'(push) - CNT_W'(pop);
        next_in_ready = next_count != CNT_W'(DEPTH);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready <= next_in_ready;
            mem <= next_mem;
        end
    end

    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

endmodule

/* design/beam_loss_limit_detector.sv */
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module beam_loss_limit_detector
    import loss_detect_pkg::*;
#(
    parameter int WINDOW_W = 16,
    parameter int CAP_DEPTH = 16,
    parameter logic [WINDOW_W-1:0] WINDOW_RST = 16'h0010
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [WORD_W-1:0] pwdata,
    output logic pready,
    output logic [WORD_W-1:0] prdata,
    output logic pslverr,
    // Sample stream
    input wire logic adc_valid,
    output logic adc_ready,
    input wire sample_pair_t adc_sample,
    // Pins
    input wire logic trig_in,
    output logic protect_out_n,
    output logic trigger_readback_out,
    output logic limit_exceeded,
    output logic [SETPOINT_W-1:0] tube_voltage_setpoint
);
    localparam int IDX_W = $clog2(CAP_DEPTH);

    initial begin
        if (WINDOW_W < 1 || WINDOW_W > WORD_W) begin
            $error("window width must lie between 1 and 32");
        end
        if (CAP_DEPTH < 2 || (CAP_DEPTH & (CAP_DEPTH - 1)) != 0) begin
            $error("capture depth must be a power of two, at least 2");
        end
    end

    // ----------------------------------------
    // Trigger readback
    // ----------------------------------------
    logic trig_meta, trig_sync;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trigger_readback_out <= 1'b0;
        end else begin
            trig_meta <= trig_in;
            trig_sync <= trig_meta;
            trigger_readback_out <= trig_sync;
        end
    end

    // ----------------------------------------
    // Sample buffer in the stream path
    // ----------------------------------------
    logic buf_valid, buf_ready;
    sample_pair_t buf_sample;

    skid_fifo #(
        .WIDTH(2 * ADC_W),
        .DEPTH(2)
    ) u_skid (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(adc_valid),
        .in_ready(adc_ready),
        .in_data(adc_sample),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_sample)
    );

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    logic [WORD_W-1:0] threshold, next_threshold;
    logic [WINDOW_W-1:0] window, next_window;
    logic [SETPOINT_W-1:0] next_setpoint;
    logic [IDX_W-1:0] cap_index, next_cap_index;
    logic next_pready, next_pslverr;
    logic [WORD_W-1:0] next_prdata;
    logic [WORD_W-1:0] rd_word;
    logic mapped, wr_now, clear_req;

    // ----------------------------------------
    // Detector and capture state
    // ----------------------------------------
    logic [WINDOW_W-1:0] run [NUM_CH];
    logic [WINDOW_W-1:0] next_run [NUM_CH];
    logic [ADC_W-1:0] ch_sample [NUM_CH];
    logic [WORD_W-1:0] cap_a [CAP_DEPTH];
    logic [WORD_W-1:0] cap_b [CAP_DEPTH];
    logic [WORD_W-1:0] next_cap_a [CAP_DEPTH];
    logic [WORD_W-1:0] next_cap_b [CAP_DEPTH];
    logic [IDX_W-1:0] wptr, next_wptr;
    logic [WINDOW_W-1:0] window_eff;
    logic next_limit, next_protect_n, take, loss_now;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    always_comb begin
        wr_now = psel && penable && pready && pwrite;
        clear_req = wr_now && (paddr == OFS_CONTROL) && pwdata[CONTROL_RESET_BIT];
        mapped = 1'b1;
        rd_word = '0;
        if (paddr == OFS_CONTROL) begin
            rd_word = '0;
        end else if (paddr == OFS_THRESHOLD) begin
            rd_word = threshold;
        end else if (paddr == OFS_WINDOW) begin
            rd_word = WORD_W'(window);
        end else if (paddr == OFS_SETPOINT) begin
            rd_word = WORD_W'(tube_voltage_setpoint);
        end else if (paddr == OFS_STATUS) begin
            rd_word[STATUS_LIMIT_BIT] = limit_exceeded;
            rd_word[STATUS_PROTECT_BIT] = protect_out_n;
            rd_word[STATUS_STALL_BIT] = !adc_ready;
            rd_word[STATUS_TRIG_BIT] = trigger_readback_out;
        end else if (paddr == OFS_CAP_INDEX) begin
            rd_word = WORD_W'(cap_index);
        end else if (paddr == OFS_CAP_DATA_A) begin
            rd_word = cap_a[cap_index];
        end else if (paddr == OFS_CAP_DATA_B) begin
            rd_word = cap_b[cap_index];
        end else if (paddr == OFS_CAP_WPTR) begin
            rd_word = WORD_W'(wptr);
        end else begin
            mapped = 1'b0;
        end

        next_pready = psel && penable && !pready;
        next_pslverr = next_pready && !mapped;
        next_prdata = (next_pready && !pwrite && mapped) ? rd_word : '0;

        next_threshold = threshold;
        next_window = window;
        next_setpoint = tube_voltage_setpoint;
        next_cap_index = cap_index;
        if (wr_now) begin
            if (paddr == OFS_THRESHOLD) begin
                next_threshold = pwdata;
            end else if (paddr == OFS_WINDOW) begin
                next_window = pwdata[WINDOW_W-1:0];
            end else if (paddr == OFS_SETPOINT) begin
                if (pwdata > WORD_W'(SETPOINT_MAX)) begin
                    next_setpoint = SETPOINT_MAX;
                end else begin
                    next_setpoint = pwdata[SETPOINT_W-1:0];
                end
            end else if (paddr == OFS_CAP_INDEX) begin
                next_cap_index = pwdata[IDX_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
            threshold <= THRESHOLD_RST;
            window <= WINDOW_RST;
            tube_voltage_setpoint <= SETPOINT_RST;
            cap_index <= '0;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
            threshold <= next_threshold;
            window <= next_window;
            tube_voltage_setpoint <= next_setpoint;
            cap_index <= next_cap_index;
        end
    end

    // ----------------------------------------
    // Threshold detection and capture
    // ----------------------------------------
    assign buf_ready = !limit_exceeded;

    always_comb begin
        ch_sample[0] = buf_sample.ch_a;
        ch_sample[1] = buf_sample.ch_b;
        window_eff = (window == '0) ? WINDOW_W'(1) : window;
        take = buf_valid && buf_ready;
        loss_now = 1'b0;
        next_run = run;
        for (int c = 0; c < NUM_CH; c++) begin
            if (take) begin
                if (at_or_above(ch_sample[c], threshold)) begin
                    if (run[c] + WINDOW_W'(1) >= window_eff) begin
                        loss_now = 1'b1;
                        next_run[c] = window_eff;
                    end else begin
                        next_run[c] = run[c] + WINDOW_W'(1);
                    end
                end else begin
                    next_run[c] = '0;
                end
            end
            if (clear_req) begin
                next_run[c] = '0;
            end
        end

        // A loss in the same cycle as a user reset still latches
        next_limit = loss_now || (limit_exceeded && !clear_req);
        next_protect_n = !next_limit;

        next_cap_a = cap_a;
        next_cap_b = cap_b;
        next_wptr = wptr;
        if (take) begin
            next_cap_a[wptr] = sign_extend(ch_sample[0]);
            next_cap_b[wptr] = sign_extend(ch_sample[1]);
            next_wptr = wptr + IDX_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            limit_exceeded <= 1'b0;
            protect_out_n <= 1'b1;
            wptr <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                run[c] <= '0;
            end
            for (int i = 0; i < CAP_DEPTH; i++) begin
                cap_a[i] <= '0;
                cap_b[i] <= '0;
            end
        end else begin
            limit_exceeded <= next_limit;
            protect_out_n <= next_protect_n;
            wptr <= next_wptr;
            run <= next_run;
            cap_a <= next_cap_a;
            cap_b <= next_cap_b;
        end
    end

endmodule

/* dv/beam_loss_checker_assertions.sv */
`timescale 1ns/1ps
module beam_loss_checker
    import loss_detect_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [WORD_W-1:0] pwdata,
    input wire logic pready,
    input wire logic [WORD_W-1:0] prdata,
    input wire logic pslverr,
    input wire logic adc_valid,
    input wire logic adc_ready,
    input wire sample_pair_t adc_sample,
    input wire logic trig_in,
    input wire logic protect_out_n,
    input wire logic trigger_readback_out,
    input wire logic limit_exceeded,
    input wire logic [SETPOINT_W-1:0] tube_voltage_setpoint
);
    // ----------------------------------------
    // Bus events
    // ----------------------------------------
    logic wr_done;
    logic clear_req;
    assign wr_done = psel && penable && pwrite && pready;
    assign clear_req = wr_done && paddr == OFS_CONTROL && pwdata[CONTROL_RESET_BIT];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence access_start;
        psel && $rose(penable);
    endsequence
    sequence setpoint_write;
        wr_done && paddr == OFS_SETPOINT;
    endsequence

    ready_timing_a: assert property (access_start |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    slverr_pair_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    prdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    setpoint_clamp_a: assert property (setpoint_write |=> tube_voltage_setpoint ==
        (($past(pwdata) > 32'h0000_04E2) ? SETPOINT_MAX : $past(pwdata[SETPOINT_W-1:0])))
        else $error("set point not written or clamped");
    protect_track_a: assert property (protect_out_n != limit_exceeded)
        else $error("protect and limit disagree");
    limit_hold_a: assert property (limit_exceeded && !clear_req |=> limit_exceeded)
        else $error("limit released without reset");
    protect_hold_a: assert property (!protect_out_n && !clear_req |=> !protect_out_n)
        else $error("protect released without reset");
    trig_echo_a: assert property (trigger_readback_out == $past(trig_in, 3))
        else $error("trigger readback wrong");
endmodule

bind beam_loss_limit_detector beam_loss_checker beam_loss_checker_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_sample(adc_sample),
    .trig_in(trig_in), .protect_out_n(protect_out_n),
    .trigger_readback_out(trigger_readback_out), .limit_exceeded(limit_exceeded),
    .tube_voltage_setpoint(tube_voltage_setpoint)
);

/* dv/adc_source_model.sv */
`timescale 1ns/1ps
module adc_source_model
    import loss_detect_pkg::*;
(
    input wire logic clk_sys,
    input wire logic adc_ready,
    output logic adc_valid,
    output sample_pair_t adc_sample
);
    initial begin
        adc_valid = 1'b0;
        adc_sample = 28'h0000000;
    end

    // Holds each pair until taken; idle data is the inverse of the last pair
    task automatic send(input sample_pair_t q[$], input int gap);
        foreach (q[i]) begin
            adc_valid <= 1'b1;
            adc_sample <= q[i];
            do @(posedge clk_sys); while (adc_ready !== 1'b1);
            if (gap > 0 || i == q.size() - 1) begin
                adc_valid <= 1'b0;
                adc_sample <= ~q[i];
                repeat (gap) @(posedge clk_sys);
            end
        end
    endtask
endmodule

/* dv/beam_loss_limit_detector_bench.sv */
`timescale 1ns/1ps
module beam_loss_limit_detector_bench;
    import loss_detect_pkg::*;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, trig_in, e;
    logic [ADDR_W-1:0] paddr;
    logic [WORD_W-1:0] pwdata, prdata, rd;
    logic adc_valid, adc_ready, protect_out_n, trigger_readback_out, limit_exceeded;
    logic [SETPOINT_W-1:0] tube_voltage_setpoint;
    sample_pair_t adc_sample;
    int err_count, checked;

    beam_loss_limit_detector beam_loss_limit_detector_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_sample(adc_sample),
        .trig_in(trig_in), .protect_out_n(protect_out_n),
        .trigger_readback_out(trigger_readback_out), .limit_exceeded(limit_exceeded),
        .tube_voltage_setpoint(tube_voltage_setpoint));
    adc_source_model adc_source_model_inst (.clk_sys(clk_sys), .adc_ready(adc_ready),
        .adc_valid(adc_valid), .adc_sample(adc_sample));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle cycle keeps the release apart from the next setup
        @(posedge clk_sys);
    endtask

    task automatic wait_limit(input logic v);
        int n = 0;
        while (limit_exceeded !== v && n < 10) begin
            @(posedge clk_sys);
            n++;
        end
    endtask

    task automatic stop_test;
        $display("Counts: %0d mismatches in %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic t_reset_values;
        chk(protect_out_n, 1'b1);
        chk(limit_exceeded, 1'b0);
        apb(1'b0, OFS_THRESHOLD, 32'h0);
        chk(rd, 32'h0000_1FFF);
        apb(1'b0, 12'h024, 32'h0);
        chk(rd, 32'h0000_0000);
        chk(e, 1'b1);
        $display("test reset_values done");
    endtask

    task automatic t_setpoint;
        apb(1'b1, OFS_SETPOINT, 32'h0000_04E2);
        repeat (2) @(posedge clk_sys);
        chk(tube_voltage_setpoint, 11'h4E2);
        apb(1'b1, OFS_SETPOINT, 32'h0000_07FF);
        repeat (2) @(posedge clk_sys);
        chk(tube_voltage_setpoint, 11'h4E2);
        $display("test setpoint done");
    endtask

    task automatic t_loss;
        apb(1'b1, OFS_THRESHOLD, 32'h0000_0064);
        apb(1'b1, OFS_WINDOW, 32'h0000_0003);
        adc_source_model_inst.send('{28'h0000064, 28'h0000064, 28'h1900032, 28'h1900064,
            28'h0000000, 28'h2583FFB, 28'h2583FFB}, 0);
        repeat (4) @(posedge clk_sys);
        chk(limit_exceeded, 1'b0);
        adc_source_model_inst.send('{28'h2583FFB}, 2);
        wait_limit(1'b1);
        chk(limit_exceeded, 1'b1);
        chk(protect_out_n, 1'b0);
        apb(1'b0, OFS_CAP_WPTR, 32'h0);
        apb(1'b1, OFS_CAP_INDEX, (rd - 32'h1) & 32'h0000_000F);
        apb(1'b0, OFS_CAP_DATA_A, 32'h0);
        chk(rd, 32'hFFFF_FFFB);
        apb(1'b0, OFS_CAP_DATA_B, 32'h0);
        chk(rd, 32'h0000_0960);
        adc_source_model_inst.send('{28'h0000000, 28'h0000000}, 0);
        repeat (2) @(posedge clk_sys);
        chk(adc_ready, 1'b0);
        chk(protect_out_n, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[1:0], 2'b01);
        $display("test loss done");
    endtask

    task automatic t_user_reset;
        apb(1'b1, OFS_CONTROL, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        chk(limit_exceeded, 1'b0);
        chk(protect_out_n, 1'b1);
        repeat (4) @(posedge clk_sys);
        chk(adc_ready, 1'b1);
        $display("test user_reset done");
    endtask

    task automatic t_trigger;
        trig_in <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk(trigger_readback_out, 1'b1);
        trig_in <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk(trigger_readback_out, 1'b0);
        $display("test trigger done");
    endtask

    initial begin
        {rst_n, psel, penable, pwrite, trig_in} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_count = 0;
        checked = 0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_reset_values();
        t_setpoint();
        t_loss();
        t_user_reset();
        t_trigger();
        stop_test();
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        err_count++;
        stop_test();
    end
endmodule
